// File: verilog/serial_port_timing.sv
// Purpose: Bit clock divider, frame sync and data edge logic of a serial port
// Assumes: Pin inputs synchronous to sys_clk; APB slave with zero wait states
// Notes: Register offsets and field positions live in the package
// Notes on behaviour
// - Select one: input is four system clocks
// - High time from divide value parity
// - Low time; period is divide plus one, two for divide zero
// - Bit clock never below least period
// - Polarity selects invert the rx clock and both sync references; tx clock polarity inverts only its pin
// - External receive sync sampled on falling edge
// - Receive data sampled on falling edge
// - Internal receive sync updated on rising edge
// - Release output after last bit, rising edge
// - Extension set adds four to eight cycles
// - Extra delay for first bit only
// - Delay zero: first bit from sync rise
// - Delay nonzero: first bit from clock rise
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module serial_port_timing #(
	parameter int WORD_MAX = 32
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sport_pkg::pins_in_t pins_in,
	input wire logic ext_clock_in,
	output sport_pkg::pins_out_t pins_out
);
	import sport_pkg::*;

	// Registers
	logic [31:0] clock_cfg_r; // Divide value and input select
	logic [31:0] port_control_reg_r; // Polarity, delay, length
	logic [31:0] tx_word_r; // Word to send
	logic [31:0] rx_word_r; // Last received word
	logic rx_done_r; // Sticky receive done
	logic tx_busy_r; // Transmit in progress
	logic tx_start_r; // Start request pulse

	// Fields
	logic [DIV_W-1:0] bit_clock_divide_value;
	logic divider_input_select, rx_clock_polarity, tx_clock_polarity;
	logic rx_sync_polarity, tx_sync_polarity, tx_enable_extension, rx_sync_gen;
	logic [1:0] tx_first_bit_delay;
	logic [4:0] word_len;
	assign bit_clock_divide_value = clock_cfg_r[DIV_LSB +: DIV_W];
	assign divider_input_select = clock_cfg_r[SEL_BIT];
	assign rx_clock_polarity = port_control_reg_r[RXCP_BIT];
	assign tx_clock_polarity = port_control_reg_r[TXCP_BIT];
	assign rx_sync_polarity = port_control_reg_r[RXSP_BIT];
	assign tx_sync_polarity = port_control_reg_r[TXSP_BIT];
	assign tx_enable_extension = port_control_reg_r[EXT_BIT];
	assign tx_first_bit_delay = port_control_reg_r[DLY_LSB +: 2];
	assign rx_sync_gen = port_control_reg_r[FSGEN_BIT];
	assign word_len = port_control_reg_r[LEN_LSB +: 5];

	// APB access strobes
	logic apb_wr, apb_rd;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;

	// Divider input tick: prescaler or external clock edge
	logic [1:0] pre_r; // Four-cycle prescaler
	logic ext_d_r; // Previous external clock level
	logic div_tick;
	assign div_tick = divider_input_select ? (pre_r == 2'h3) : (ext_clock_in && !ext_d_r);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_r <= 2'h0;
			ext_d_r <= 1'b0;
		end else if (clk_en) begin
			pre_r <= pre_r + 2'h1;
			ext_d_r <= ext_clock_in;
		end
	end

	// High and low counts from divide value
	logic [DIV_W:0] high_cnt, low_cnt, div_p1;
	always_comb begin
		div_p1 = {1'b0, bit_clock_divide_value} + 9'h001;
		if (bit_clock_divide_value != '0 && !bit_clock_divide_value[0]) begin
			high_cnt = {2'b00, bit_clock_divide_value[DIV_W-1:1]} + 9'h001;
			low_cnt = {2'b00, bit_clock_divide_value[DIV_W-1:1]};
		end else begin
			high_cnt = {1'b0, div_p1[DIV_W:1]};
			low_cnt = {1'b0, div_p1[DIV_W:1]};
		end
	end

	// Divider counter and generated bit clock
	logic [DIV_W:0] div_cnt_r; // Input periods left in phase
	logic gen_clk_r; // Generated clock, high phase first
	logic gen_rise, gen_fall;
	assign gen_rise = div_tick && !gen_clk_r && div_cnt_r <= 9'h001;
	assign gen_fall = div_tick && gen_clk_r && div_cnt_r <= 9'h001;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_r <= 9'h001;
			gen_clk_r <= 1'b0;
		end else if (clk_en && div_tick) begin
			if (div_cnt_r <= 9'h001) begin
				gen_clk_r <= !gen_clk_r;
				div_cnt_r <= gen_clk_r ? low_cnt : high_cnt;
			end else begin
				div_cnt_r <= div_cnt_r - 9'h001;
			end
		end
	end

	// Receive side: polarity-corrected external pins
	logic rx_clk_lvl_r, rx_fs_in;
	logic rx_clk_ref;
	assign rx_clk_ref = pins_in.rx_bit_clock ^ rx_clock_polarity;
	assign rx_fs_in = pins_in.rx_frame_sync ^ rx_sync_polarity;
	logic rx_fall, rx_rise;
	assign rx_fall = rx_clk_lvl_r && !rx_clk_ref;
	assign rx_rise = !rx_clk_lvl_r && rx_clk_ref;

	// Receive shift on falling edge of reference clock
	logic [4:0] rx_cnt_r; // Bits left in receive word
	logic rx_act_r; // Receive word active
	logic [31:0] rx_sh_r; // Receive shifter
	logic rx_fs_gen_r; // Internally generated receive sync
	logic [4:0] rx_gen_cnt_r; // Bits until next generated sync
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_clk_lvl_r <= 1'b0;
			rx_cnt_r <= 5'h00;
			rx_act_r <= 1'b0;
			rx_sh_r <= 32'h0000_0000;
			rx_word_r <= 32'h0000_0000;
			rx_done_r <= 1'b0;
		end else if (clk_en) begin
			rx_clk_lvl_r <= rx_clk_ref;
			if (rx_fall && (rx_sync_gen ? rx_fs_gen_r : rx_fs_in) && !rx_act_r) begin
				rx_act_r <= 1'b1;
				rx_cnt_r <= word_len;
				rx_sh_r <= 32'h0000_0000; // Old bits never leak into a new word
			end else if (rx_fall && rx_act_r) begin
				rx_sh_r <= {rx_sh_r[30:0], pins_in.rx_serial_in};
				if (rx_cnt_r == 5'h00) begin
					rx_act_r <= 1'b0;
					rx_word_r <= {rx_sh_r[30:0], pins_in.rx_serial_in};
				end else begin
					rx_cnt_r <= rx_cnt_r - 5'h01;
				end
			end
			// Set wins over a clear by status read
			if (rx_fall && rx_act_r && rx_cnt_r == 5'h00)
				rx_done_r <= 1'b1;
			else if (apb_rd && paddr == OFF_STATUS)
				rx_done_r <= 1'b0;
		end
	end

	// Internal receive sync from rising reference edges
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_fs_gen_r <= 1'b0;
			rx_gen_cnt_r <= 5'h00;
		end else if (clk_en && rx_rise) begin
			rx_fs_gen_r <= (rx_gen_cnt_r == 5'h00);
			rx_gen_cnt_r <= (rx_gen_cnt_r == 5'h00) ? word_len + 5'h01 : rx_gen_cnt_r - 5'h01;
		end
	end

	// Transmit side: generated clock drives the tx bit clock pin
	logic tx_ref, tx_ref_d_r, tx_rise, tx_fs_ref, tx_fs_d_r, tx_fs_rise;
	assign tx_ref = gen_clk_r;
	assign tx_rise = tx_ref && !tx_ref_d_r;
	assign tx_fs_ref = pins_in.tx_frame_sync ^ tx_sync_polarity;
	assign tx_fs_rise = tx_fs_ref && !tx_fs_d_r;

	// Transmit state machine
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_EXT, TX_SHIFT} tx_state_t;
	tx_state_t tx_st_r;
	logic [31:0] tx_sh_r; // Transmit shifter
	logic [4:0] tx_cnt_r; // Bits left after current
	logic [2:0] ext_cnt_r; // Extra delay counter
	logic tx_out_r, tx_oe_n_r; // Pin drivers
	logic launch; // First bit launch event
	assign launch = (tx_first_bit_delay == 2'b00) ? tx_fs_rise : tx_rise;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_r <= TX_IDLE;
			tx_sh_r <= 32'h0000_0000;
			tx_cnt_r <= 5'h00;
			ext_cnt_r <= 3'h0;
			tx_out_r <= 1'b0;
			tx_oe_n_r <= 1'b1;
			tx_busy_r <= 1'b0;
			tx_ref_d_r <= 1'b0;
			tx_fs_d_r <= 1'b0;
		end else if (clk_en) begin
			tx_ref_d_r <= tx_ref;
			tx_fs_d_r <= tx_fs_ref;
			case (tx_st_r)
				TX_IDLE: begin
					if (tx_start_r) begin
						tx_sh_r <= tx_word_r;
						tx_cnt_r <= word_len;
						tx_busy_r <= 1'b1;
						tx_st_r <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					if (launch && tx_enable_extension) begin
						ext_cnt_r <= EXT_DELAY_CYCLES;
						tx_st_r <= TX_EXT;
					end else if (launch) begin
						tx_out_r <= tx_sh_r[31];
						tx_oe_n_r <= 1'b0;
						tx_st_r <= TX_SHIFT;
					end
				end
				TX_EXT: begin
					if (ext_cnt_r <= 3'h1) begin
						tx_out_r <= tx_sh_r[31];
						tx_oe_n_r <= 1'b0;
						tx_st_r <= TX_SHIFT;
					end else begin
						ext_cnt_r <= ext_cnt_r - 3'h1;
					end
				end
				TX_SHIFT: begin
					if (tx_rise) begin
						if (tx_cnt_r == 5'h00) begin
							tx_oe_n_r <= 1'b1;
							tx_busy_r <= 1'b0;
							tx_st_r <= TX_IDLE;
						end else begin
							tx_sh_r <= {tx_sh_r[30:0], 1'b0};
							tx_out_r <= tx_sh_r[30];
							tx_cnt_r <= tx_cnt_r - 5'h01;
						end
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// Pin outputs, all registered
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pins_out <= '0;
			pins_out.tx_serial_oe_n <= 1'b1;
		end else if (clk_en) begin
			pins_out.tx_bit_clock <= gen_clk_r ^ tx_clock_polarity;
			pins_out.rx_bit_clock <= gen_clk_r ^ rx_clock_polarity;
			pins_out.rx_frame_sync <= rx_fs_gen_r ^ rx_sync_polarity;
			pins_out.tx_serial_out <= tx_out_r;
			pins_out.tx_serial_oe_n <= tx_oe_n_r;
		end
	end

	// APB register writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clock_cfg_r <= CLOCK_CFG_RST;
			port_control_reg_r <= PORT_CTRL_RST;
			tx_word_r <= 32'h0000_0000;
			tx_start_r <= 1'b0;
		end else if (clk_en) begin
			tx_start_r <= 1'b0;
			if (apb_wr) begin
				case (paddr)
					OFF_CLOCK_CFG: clock_cfg_r <= pwdata & 32'h0000_01ff;
					OFF_PORT_CTRL: port_control_reg_r <= pwdata & 32'h0000_1fff;
					OFF_TX_DATA: begin
						tx_word_r <= pwdata;
						tx_start_r <= !tx_busy_r;
					end
					default: ;
				endcase
			end
		end
	end

	// APB read data and response
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !(paddr inside {OFF_CLOCK_CFG, OFF_PORT_CTRL,
				OFF_TX_DATA, OFF_RX_DATA, OFF_STATUS});
			case (paddr)
				OFF_CLOCK_CFG: prdata <= clock_cfg_r;
				OFF_PORT_CTRL: prdata <= port_control_reg_r;
				OFF_TX_DATA: prdata <= tx_word_r;
				OFF_RX_DATA: prdata <= rx_word_r;
				OFF_STATUS: prdata <= {29'h0, gen_clk_r, tx_busy_r, rx_done_r};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // serial_port_timing
`default_nettype wire

// File: verilog/sport_pkg.sv
// Purpose: Shared constants and types for the serial port timing block
// Assumes: 125 MHz system clock, APB register access
// Notes: Register offsets are byte addresses of aligned 32-bit words
package sport_pkg;
	// Clock period in ns as printed for this system
	localparam int CLK_PERIOD_NS = 8;
	// Divider input from internal clock: four system clocks
	localparam int DIV_IN_CPU_CYCLES = 4;
	// Least bit clock period in ns (6.67 ns) expressed in hundredths of a ns
	localparam int MIN_BIT_PERIOD_PS10 = 667;
	// Least bit clock period in cycles, rounded up, at least four
	localparam int MIN_BIT_CYCLES_NS = (MIN_BIT_PERIOD_PS10 + CLK_PERIOD_NS * 100 - 1)
		/ (CLK_PERIOD_NS * 100);
	localparam int MIN_BIT_CYCLES = (MIN_BIT_CYCLES_NS > 4) ? MIN_BIT_CYCLES_NS : 4;
	// Extra first-bit delay bounds in system clocks
	localparam int EXT_DELAY_MIN = 4;
	localparam int EXT_DELAY_MAX = 8;
	localparam logic [2:0] EXT_DELAY_CYCLES = 3'h6;
	// Register offsets
	localparam logic [7:0] OFF_CLOCK_CFG = 8'h00;
	localparam logic [7:0] OFF_PORT_CTRL = 8'h04;
	localparam logic [7:0] OFF_TX_DATA = 8'h08;
	localparam logic [7:0] OFF_RX_DATA = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	// Clock config fields
	localparam int DIV_LSB = 0;
	localparam int DIV_W = 8;
	localparam int SEL_BIT = 8;
	// Port control fields
	localparam int RXCP_BIT = 0;
	localparam int TXCP_BIT = 1;
	localparam int RXSP_BIT = 2;
	localparam int TXSP_BIT = 3;
	localparam int EXT_BIT = 4;
	localparam int DLY_LSB = 5;
	localparam int FSGEN_BIT = 7;
	localparam int LEN_LSB = 8;
	// Reset values
	localparam logic [31:0] CLOCK_CFG_RST = 32'h0000_0101;
	localparam logic [31:0] PORT_CTRL_RST = 32'h0000_0f00;
	// Serial pin group toward the far party
	typedef struct packed {
		logic rx_bit_clock;
		logic tx_bit_clock;
		logic rx_frame_sync;
		logic tx_frame_sync;
		logic rx_serial_in;
	} pins_in_t;
	typedef struct packed {
		logic tx_bit_clock;
		logic rx_bit_clock;
		logic rx_frame_sync;
		logic tx_serial_out;
		logic tx_serial_oe_n;
	} pins_out_t;
endpackage

// File: testbench/sport_sva.sv
// Purpose: Port checks for serial_port_timing
// Assumes: One clock domain, transmit clock polarity left at default
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sport_sva import sport_pkg::*; (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire pins_out_t pins_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Bus answer timing and zero data on refused reads
	AST_ANSWER: assert property (psel && !penable |=> pready) else $error("late answer");
	AST_PULSE: assert property (pready |=> !pready) else $error("answer too long");
	AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	// Transmit clock levels and receive clock high last at least four system clocks
	AST_TX_HIGH: assert property ($rose(pins_out.tx_bit_clock) |-> pins_out.tx_bit_clock [*4])
		else $error("tx clock high too short");
	AST_TX_LOW: assert property ($fell(pins_out.tx_bit_clock) |-> !pins_out.tx_bit_clock [*4])
		else $error("tx clock low too short");
	AST_RX_HIGH: assert property ($rose(pins_out.rx_bit_clock) && $changed(pins_out.tx_bit_clock) |-> pins_out.rx_bit_clock [*4])
		else $error("rx clock high too short");
	// Release of the data line in the clock high phase
	AST_RELEASE: assert property ($rose(pins_out.tx_serial_oe_n) |-> pins_out.tx_bit_clock)
		else $error("release off clock high");
	// Frozen state while clock enable is low, data line released out of reset
	AST_FREEZE: assert property (!clk_en |=> $stable(pins_out))
		else $error("pins moved while frozen");
	AST_IDLE: assert property ($rose(arst_n) |-> pins_out.tx_serial_oe_n) else $error("driving at reset");
	C_REFUSED: cover property (pready && pslverr);
	C_DRIVE: cover property ($fell(pins_out.tx_serial_oe_n));
	C_FREEZE: cover property (!clk_en);
endmodule // sport_sva
bind serial_port_timing sport_sva u_sport_sva (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pins_out(pins_out));
`default_nettype wire

// File: testbench/sport_peer.sv
// Purpose: Far party sending one receive word and a divider clock
// Assumes: Bit clock looped back from the generated receive clock
// Notes: Idle data line toggles each bit so stale values never match
`timescale 1ns/1ps
`default_nettype none
module sport_peer (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic bit_clk,
	input wire logic on_fall,
	input wire logic go,
	input wire logic [7:0] word,
	output logic fs,
	output logic sd,
	output logic ext_clk
);
	logic prev_r;
	logic req_r;
	logic [3:0] div_r;
	logic [3:0] left_r;
	logic [7:0] sh_r;
	// Launch edge, opposite to the sampling edge
	wire logic edge_w = (bit_clk != prev_r) && (bit_clk != on_fall);
	// Divider clock, ten system clocks, even duty
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= 4'h0;
			ext_clk <= 1'b0;
		end else begin
			div_r <= (div_r == 4'h4) ? 4'h0 : div_r + 4'h1;
			ext_clk <= (div_r == 4'h4) ? !ext_clk : ext_clk;
		end
	end
	// Frame sync one bit ahead of the word, then MSB first
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= 1'b0;
			req_r <= 1'b0;
			left_r <= 4'h0;
			sh_r <= 8'h00;
			fs <= 1'b0;
			sd <= 1'b0;
		end else begin
			prev_r <= bit_clk;
			req_r <= go ? 1'b1 : (edge_w ? 1'b0 : req_r);
			if (edge_w) begin
				fs <= req_r;
				sd <= (!req_r && left_r != 4'h0) ? sh_r[7] : !sd;
				sh_r <= req_r ? word : {sh_r[6:0], 1'b0};
				left_r <= req_r ? 4'h8 : (left_r != 4'h0 ? left_r - 4'h1 : 4'h0);
			end
		end
	end
endmodule // sport_peer
`default_nettype wire

// File: testbench/tb_serial_port_timing.sv
// Purpose: Self-checking bench for serial_port_timing
// Assumes: APB master, peer model on the receive side
// Notes: Divider, receive, transmit and launch delay checks
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_timing;
	import sport_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic go = 1'b0;
	logic on_fall = 1'b0;
	logic txfs = 1'b0;
	logic [7:0] word = 8'h00;
	logic [31:0] prdata, q;
	logic pready, pslverr, e, pfs, psd, ext_clk;
	logic [7:0] w;
	int num_errors = 0;
	int compares = 0;
	int h, l, s, dv, lat, lat0;
	pins_out_t pins_out;
	pins_in_t pins_in;
	// Receive clock looped back, sync and data from the peer
	assign pins_in = '{pins_out.rx_bit_clock, 1'b0, pfs, txfs, psd};
	serial_port_timing u_serial_port_timing (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
		.ext_clock_in(ext_clk), .pins_out(pins_out));
	sport_peer u_sport_peer (.sys_clk(sys_clk), .arst_n(arst_n), .bit_clk(pins_out.rx_bit_clock),
		.on_fall(on_fall), .go(go), .word(word), .fs(pfs), .sd(psd), .ext_clk(ext_clk));
	initial begin
		forever #4 sys_clk = !sys_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Length of one transmit clock level in system clocks
	task automatic lvl(input logic v, output int n);
		n = 0;
		while (pins_out.tx_bit_clock !== v) @(posedge sys_clk);
		while (pins_out.tx_bit_clock === v) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	// Eight bits taken at transmit clock falls
	task automatic cap(output logic [7:0] b);
		logic p;
		b = 8'h00;
		while (pins_out.tx_serial_oe_n !== 1'b0) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			do begin
				p = pins_out.tx_bit_clock;
				@(posedge sys_clk);
			end while (!(p === 1'b1 && pins_out.tx_bit_clock === 1'b0));
			b = {b[6:0], pins_out.tx_serial_out};
		end
	endtask
	// Wait for the data line to be let go
	task automatic rel();
		for (int i = 0; i < 300 && pins_out.tx_serial_oe_n !== 1'b1; i++) @(posedge sys_clk);
		check("released", pins_out.tx_serial_oe_n, 1'b1);
	endtask
	// Hang guard
	initial begin
		#400us;
		num_errors++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		apb(1'b0, OFF_CLOCK_CFG, 32'h0, q, e);
		check("clock cfg", q, CLOCK_CFG_RST);
		apb(1'b0, OFF_PORT_CTRL, 32'h0, q, e);
		check("port ctrl", q, PORT_CTRL_RST);
		apb(1'b0, 8'h3c, 32'h0, q, e);
		check("unmapped", {q[30:0], e}, 32'h1);
		// Divide values 1 to 4 internal, then 2 from the pin
		for (int d = 1; d < 6; d++) begin
			apb(1'b1, OFF_CLOCK_CFG, (d == 5) ? 32'h2 : 32'h100 | d, q, e);
			dv = (d == 5) ? 2 : d;
			s = (d == 5) ? 10 : DIV_IN_CPU_CYCLES;
			repeat (2) begin
				lvl(1'b1, h);
				lvl(1'b0, l);
			end
			check("high time", h, s * (dv % 2 ? (dv + 1) / 2 : dv / 2 + 1));
			check("low time", l, s * (dv % 2 ? (dv + 1) / 2 : dv / 2));
		end
		apb(1'b1, OFF_CLOCK_CFG, 32'h103, q, e);
		clk_en <= 1'b0;
		repeat (20) @(posedge sys_clk);
		clk_en <= 1'b1;
		// Receive a word at both clock polarities
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, OFF_PORT_CTRL, 32'h700 | p, q, e);
			on_fall <= p[0];
			word <= p ? 8'h3c : 8'ha5;
			go <= 1'b1;
			@(posedge sys_clk);
			go <= 1'b0;
			q = 32'h0;
			for (int i = 0; i < 300 && q[0] !== 1'b1; i++) apb(1'b0, OFF_STATUS, 32'h0, q, e);
			apb(1'b0, OFF_RX_DATA, 32'h0, q, e);
			check("rx word", q, {24'h0, word});
		end
		// Transmit from clock rise, with and without extension
		for (int x = 0; x < 2; x++) begin
			apb(1'b1, OFF_PORT_CTRL, 32'h720 | (x << 4), q, e);
			apb(1'b1, OFF_TX_DATA, (32'hc3 ^ x) << 24, q, e);
			cap(w);
			check("tx word", w, 32'hc3 ^ x);
			rel();
		end
		// Launch from frame sync, extension adds a fixed span
		for (int x = 0; x < 2; x++) begin
			apb(1'b1, OFF_PORT_CTRL, 32'h700 | (x << 4), q, e);
			apb(1'b1, OFF_TX_DATA, 32'h8100_0000, q, e);
			repeat (2) @(posedge sys_clk);
			txfs <= 1'b1;
			lat = 0;
			while (pins_out.tx_serial_oe_n !== 1'b0 && lat < 50) begin
				@(posedge sys_clk);
				lat++;
			end
			txfs <= 1'b0;
			lat0 = x ? lat0 : lat;
			rel();
		end
		check("sync launch", lat0 < 8, 1'b1);
		check("ext delay", lat - lat0 >= EXT_DELAY_MIN && lat - lat0 <= EXT_DELAY_MAX, 1'b1);
		end_of_test();
	end
endmodule // tb_serial_port_timing
`default_nettype wire
